// file: rtl/clock_source_pkg.sv
package clock_source_pkg;
  localparam logic [5:0] REG_PROT = 6'h00;
  localparam logic [5:0] REG_ENABLE = 6'h04;
  localparam logic [5:0] REG_FAST = 6'h08;
  localparam logic [5:0] REG_LP = 6'h0C;
  localparam logic [5:0] REG_HS = 6'h10;
  localparam logic [5:0] REG_FLAG = 6'h14;
  localparam logic [5:0] REG_IRQEN = 6'h18;
  localparam logic [5:0] REG_STATUS = 6'h1C;
  localparam logic [5:0] REG_SYSTEM_CLOCK = 6'h20;
  localparam logic [15:0] PROT_KEY = 16'h0096;
  localparam logic [1:0] FAST_FQ_8M = 2'h2;
  localparam logic [1:0] HS_FQ_16M = 2'h3;
  localparam logic [3:0] ENABLE_RST = 4'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int WAIT_W = 15;
  localparam int FAST_WAIT = 16;
  localparam int CLK_MHZ = 20;
  localparam int STOP_TIME_US = 100;
  localparam int STOP_CYC = STOP_TIME_US * CLK_MHZ;
  localparam int I_FAST = 0;
  localparam int I_LP = 1;
  localparam int I_HS = 2;
  localparam int I_EXT = 3;
  localparam int I_STOP = 3;
  typedef enum logic [1:0] {SRC_FAST, SRC_LP, SRC_HS, SRC_EXT} clk_src_e;
  typedef struct packed {
    logic [5:0] high_trim;
    logic [5:0] low_trim;
    logic [1:0] fq;
  } fast_cfg_s;
  typedef struct packed {
    logic restart_en;
    logic stop_det_en;
    logic [5:0] trim;
    logic [2:0] gate_cap;
    logic [1:0] boost_gain;
    logic [1:0] normal_gain;
    logic boost_en;
    logic xtal;
    logic [1:0] wait_sel;
  } lp_cfg_s;
  typedef struct packed {
    logic autotrim_req;
    logic [1:0] fq;
    logic xtal;
    logic [2:0] wait_sel;
  } hs_cfg_s;
  typedef struct packed {
    clk_src_e sys_src;
    logic [1:0] fast_fq;
    logic [5:0] fast_trim;
    logic lp_xtal;
    logic [1:0] lp_gain;
    logic lp_boost;
    logic [2:0] gate_cap;
    logic [5:0] lp_trim;
    logic hs_xtal;
    logic [1:0] hs_fq;
    logic hs_autotrim;
  } osc_cfg_s;
endpackage : clock_source_pkg

// file: rtl/oscillator_source_startup_control.sv
// Overview of operation
// - after reset the system clock source is the fast internal oscillator
// - two-bit field selects the fast internal oscillator frequency
// - separate six-bit trims for 2/1 MHz and for 8 MHz fast settings
// - fast internal wait is fixed at sixteen of its own clock cycles
// - low-power wait set by two bits, high-speed wait by three bits
// - clock withheld during wait; at end flag sets and clock passes
// - every enable runs the full wait even with a stale flag
// - boost enable gives high inverter gain for a set period after enable
// - external clock has no wait; software enables it only when stable
// - writing one clears a ready flag; each flag has an interrupt enable
// - protected settings writable only after key 0x0096; other value relocks
// - low-power type select plus crystal gain, gate capacitor, boost gain
// - low-power oscillator has a six-bit fine trim for internal mode
// - high-speed internal frequency chosen by a two-bit field
// - stop detector senses lost low-power crystal oscillation and restarts it
// - auto-trim takes effect only with high-speed frequency select 0x3
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module osc_startup #(
  parameter int W = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_pin,
  input wire logic enable,
  input wire logic [W-1:0] wait_cycles,
  output logic ready,
  output logic done,
  output logic edge_seen
);
  logic s1_q, s2_q, s3_q;
  logic [W-1:0] cnt_q;
  logic rise;
  assign rise = s2_q & ~s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      s1_q <= osc_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_seen <= rise;
    end
  end

  // a dropped enable clears the count, so a stale flag never shortens it
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      cnt_q <= '0;
      ready <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!ready && rise) begin
        if (cnt_q == wait_cycles - 1'b1) begin
          ready <= 1'b1;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  property p_wait_end;
    @(posedge clk) disable iff (rst)
      enable && !ready && rise && cnt_q == wait_cycles - 1'b1 |=> ready && done;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait end missed");
  property p_no_early;
    @(posedge clk) disable iff (rst)
      !ready && !(rise && cnt_q == wait_cycles - 1'b1) |=> !ready || !$past(enable);
  endproperty
  a_no_early: assert property (p_no_early) else $error("ready too early");
endmodule : osc_startup

module oscillator_source_startup_control #(
  parameter int LP_WAIT_EXP0 = 14,
  parameter int HS_WAIT_EXP0 = 14,
  parameter int BOOST_LP_CYCLES = 1024
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic fast_internal_clock,
  input wire logic low_power_clock,
  input wire logic high_speed_clock,
  output logic [3:0] osc_run,
  output logic [3:0] clk_gate,
  output clock_source_pkg::osc_cfg_s osc_cfg,
  output logic irq
);
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q, en_q, flag_q, irqen_q;
  logic unlocked_q, restart_q, stop_q;
  clock_source_pkg::fast_cfg_s fast_q;
  clock_source_pkg::lp_cfg_s lp_q;
  clock_source_pkg::hs_cfg_s hs_q;
  clock_source_pkg::clk_src_e system_clock_q;
  logic [11:0] stop_cnt_q;
  logic [15:0] boost_cnt_q;
  logic wr_fire, lp_en, boost_act;
  logic fast_rdy, lp_rdy, hs_rdy, fast_done, lp_done, hs_done, lp_edge;
  logic [5:0] wa;
  logic [31:0] m, wv;
  logic [3:0] rdy, set_v, clr_v;
  logic [14:0] lp_wait, hs_wait;

  function automatic logic hit(input logic [31:0] a);
    hit = a[31:6] == '0 && a[1:0] == 2'h0 && a[5:0] <= clock_source_pkg::REG_SYSTEM_CLOCK;
  endfunction : hit

  function automatic logic [31:0] rd(input logic [5:0] a);
    case (a)
      clock_source_pkg::REG_PROT: rd = {31'h0, unlocked_q};
      clock_source_pkg::REG_ENABLE: rd = {28'h0, en_q};
      clock_source_pkg::REG_FAST: rd = {18'h0, fast_q};
      clock_source_pkg::REG_LP: rd = {13'h0, lp_q};
      clock_source_pkg::REG_HS: rd = {25'h0, hs_q};
      clock_source_pkg::REG_FLAG: rd = {28'h0, flag_q};
      clock_source_pkg::REG_IRQEN: rd = {28'h0, irqen_q};
      clock_source_pkg::REG_STATUS: rd = {26'h0, boost_act, restart_q, rdy};
      clock_source_pkg::REG_SYSTEM_CLOCK: rd = {30'h0, system_clock_q};
      default: rd = 32'h0;
    endcase
  endfunction : rd

  // unmapped writes decode to no register, so a high address bit cannot alias
  assign wa = hit(awaddr_q) ? awaddr_q[5:0] : 6'h3F;
  assign wr_fire = !awready && !wready && !bvalid;
  assign m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wv = (rd(wa) & ~m) | (wdata_q & m);

  // write channels are taken independently; the response waits for both
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= clock_source_pkg::RESP_OKAY;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= hit(awaddr_q) ? clock_source_pkg::RESP_OKAY : clock_source_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= clock_source_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= hit(araddr) ? rd(araddr[5:0]) : 32'h0;
      rresp <= hit(araddr) ? clock_source_pkg::RESP_OKAY : clock_source_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // locked writes still answer OKAY but leave the protected registers unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      unlocked_q <= 1'b0;
      fast_q <= '0;
      lp_q <= '0;
      hs_q <= '0;
      system_clock_q <= clock_source_pkg::SRC_FAST;
    end else if (wr_fire) begin
      if (wa == clock_source_pkg::REG_PROT) begin
        unlocked_q <= wv[15:0] == clock_source_pkg::PROT_KEY;
      end
      if (unlocked_q) begin
        case (wa)
          clock_source_pkg::REG_FAST: fast_q <= wv[13:0];
          clock_source_pkg::REG_LP: lp_q <= wv[18:0];
          clock_source_pkg::REG_HS: hs_q <= wv[6:0];
          clock_source_pkg::REG_SYSTEM_CLOCK: system_clock_q <= clock_source_pkg::clk_src_e'(wv[1:0]);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= clock_source_pkg::ENABLE_RST;
      irqen_q <= 4'h0;
    end else if (wr_fire && wa == clock_source_pkg::REG_ENABLE) begin
      en_q <= wv[3:0];
    end else if (wr_fire && wa == clock_source_pkg::REG_IRQEN) begin
      irqen_q <= wv[3:0];
    end
  end

  // set beats a same-cycle clear so no completion is lost
  assign set_v = {stop_q, hs_done, lp_done, fast_done};
  assign clr_v = (wr_fire && wa == clock_source_pkg::REG_FLAG)
    ? (wdata_q[3:0] & {4{wstrb_q[0]}}) : 4'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      flag_q <= (flag_q & ~clr_v) | set_v;
      irq <= |(flag_q & irqen_q);
    end
  end

  // shorter exponents shrink the wait tables for simulation
  assign lp_wait = 15'h0001 << 4'(LP_WAIT_EXP0 - 2 * int'(lp_q.wait_sel));
  assign hs_wait = 15'h0001 << 4'(HS_WAIT_EXP0 - int'(hs_q.wait_sel));
  assign lp_en = en_q[clock_source_pkg::I_LP] && !restart_q;

  osc_startup #(.W(clock_source_pkg::WAIT_W)) u_fast (
    .clk(clk),
    .rst(rst),
    .osc_pin(fast_internal_clock),
    .enable(en_q[clock_source_pkg::I_FAST]),
    .wait_cycles(15'(clock_source_pkg::FAST_WAIT)),
    .ready(fast_rdy),
    .done(fast_done),
    .edge_seen()
  );
  osc_startup #(.W(clock_source_pkg::WAIT_W)) u_lp (
    .clk(clk),
    .rst(rst),
    .osc_pin(low_power_clock),
    .enable(lp_en),
    .wait_cycles(lp_wait),
    .ready(lp_rdy),
    .done(lp_done),
    .edge_seen(lp_edge)
  );
  osc_startup #(.W(clock_source_pkg::WAIT_W)) u_hs (
    .clk(clk),
    .rst(rst),
    .osc_pin(high_speed_clock),
    .enable(en_q[clock_source_pkg::I_HS]),
    .wait_cycles(hs_wait),
    .ready(hs_rdy),
    .done(hs_done),
    .edge_seen()
  );
  assign rdy = {en_q[clock_source_pkg::I_EXT], hs_rdy, lp_rdy, fast_rdy};

  // timeout is far above one 32 kHz period (about 610 cycles)
  always_ff @(posedge clk) begin
    if (rst || !lp_rdy || !lp_q.xtal || !lp_q.stop_det_en || lp_edge) begin
      stop_cnt_q <= 12'h000;
      stop_q <= 1'b0;
      restart_q <= 1'b0;
    end else if (stop_cnt_q == 12'(clock_source_pkg::STOP_CYC - 1)) begin
      stop_cnt_q <= 12'h000;
      stop_q <= 1'b1;
      restart_q <= lp_q.restart_en;
    end else begin
      stop_cnt_q <= stop_cnt_q + 12'h001;
      stop_q <= 1'b0;
      restart_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !lp_en) begin
      boost_cnt_q <= 16'h0000;
    end else if (lp_edge && boost_cnt_q != 16'(BOOST_LP_CYCLES)) begin
      boost_cnt_q <= boost_cnt_q + 16'h0001;
    end
  end
  assign boost_act = lp_en && lp_q.boost_en && lp_q.xtal
    && boost_cnt_q != 16'(BOOST_LP_CYCLES);

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_cfg <= '0;
      osc_run <= 4'h0;
      clk_gate <= 4'h0;
    end else begin
      osc_run <= {en_q[clock_source_pkg::I_EXT], en_q[clock_source_pkg::I_HS], lp_en,
        en_q[clock_source_pkg::I_FAST]};
      clk_gate <= rdy;
      osc_cfg.sys_src <= system_clock_q;
      osc_cfg.fast_fq <= fast_q.fq;
      osc_cfg.fast_trim <= fast_q.fq == clock_source_pkg::FAST_FQ_8M ? fast_q.high_trim
        : fast_q.low_trim;
      osc_cfg.lp_xtal <= lp_q.xtal;
      osc_cfg.lp_gain <= boost_act ? lp_q.boost_gain : lp_q.normal_gain;
      osc_cfg.lp_boost <= boost_act;
      osc_cfg.gate_cap <= lp_q.gate_cap;
      osc_cfg.lp_trim <= lp_q.trim;
      osc_cfg.hs_xtal <= hs_q.xtal;
      osc_cfg.hs_fq <= hs_q.fq;
      osc_cfg.hs_autotrim <= hs_q.autotrim_req && hs_q.fq == clock_source_pkg::HS_FQ_16M;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_boot_src;
    @(posedge clk) disable iff (1'b0) rst |=> osc_cfg.sys_src == clock_source_pkg::SRC_FAST;
  endproperty
  a_boot_src: assert property (p_boot_src) else $error("boot source wrong");
  property p_relock;
    wr_fire && wa == clock_source_pkg::REG_PROT && wv[15:0] != clock_source_pkg::PROT_KEY
      |=> !unlocked_q;
  endproperty
  a_relock: assert property (p_relock) else $error("relock failed");
  property p_locked_hold;
    !unlocked_q && wr_fire |=> $stable(fast_q) && $stable(lp_q) && $stable(hs_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked write took");
  property p_restart_wait;
    $rose(lp_en) |=> !lp_rdy ##1 !clk_gate[clock_source_pkg::I_LP];
  endproperty
  a_restart_wait: assert property (p_restart_wait) else $error("wait skipped");
  property p_flag_irq;
    $rose(lp_rdy) ##1 irqen_q[clock_source_pkg::I_LP] |=> irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag irq missing");
  property p_w1c;
    wr_fire && wa == clock_source_pkg::REG_FLAG && wstrb_q[0] && wdata_q[0] && !fast_done
      |=> !flag_q[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_ext_pass;
    $rose(en_q[clock_source_pkg::I_EXT]) |=> clk_gate[clock_source_pkg::I_EXT];
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("ext clock held");
  property p_boost_end;
    boost_act && lp_edge && boost_cnt_q == 16'(BOOST_LP_CYCLES - 1) |=> !boost_act ##1
      osc_cfg.lp_gain == $past(lp_q.normal_gain);
  endproperty
  a_boost_end: assert property (p_boost_end) else $error("boost overran");
  property p_trim_sel;
    fast_q.fq == clock_source_pkg::FAST_FQ_8M |=> osc_cfg.fast_trim == $past(fast_q.high_trim);
  endproperty
  a_trim_sel: assert property (p_trim_sel) else $error("trim select wrong");
  property p_autotrim;
    hs_q.fq != clock_source_pkg::HS_FQ_16M |=> !osc_cfg.hs_autotrim;
  endproperty
  a_autotrim: assert property (p_autotrim) else $error("autotrim off 16 MHz");
  property p_stop_restart;
    restart_q |=> !lp_rdy && flag_q[clock_source_pkg::I_STOP];
  endproperty
  a_stop_restart: assert property (p_stop_restart) else $error("no restart");
  c_lp_ready: cover property ($rose(lp_rdy));
  c_stop: cover property (restart_q);
  c_unlock: cover property ($rose(unlocked_q));
  c_irq: cover property ($rose(irq));
endmodule : oscillator_source_startup_control

// file: test/osc_clock_model.sv
`timescale 1ns/1ns
module osc_clock_model (
  input wire logic [3:0] osc_run,
  input wire logic lp_stall,
  output logic fast_internal_clock,
  output logic low_power_clock,
  output logic high_speed_clock,
  output logic [2:0][15:0] edge_cnt
);
  logic [2:0] osc_q;
  assign fast_internal_clock = osc_q[0];
  assign low_power_clock = osc_q[1];
  assign high_speed_clock = osc_q[2];
  // halted or stalled resonator stands still low, no stale toggling
  task automatic spin(input int i, input int half);
    forever begin
      osc_q[i] = 1'b0;
      wait (osc_run[i] && !(i == 1 && lp_stall));
      #(half);
      if (osc_run[i] && !(i == 1 && lp_stall)) begin
        osc_q[i] = 1'b1;
        edge_cnt[i] = edge_cnt[i] + 16'h0001;
        #(half);
      end
    end
  endtask : spin
  for (genvar g = 0; g < 3; g++) begin : g_clr
    always @(posedge osc_run[g]) edge_cnt[g] = 16'h0000;
  end
  // half periods off the clk grid, period well above the synchroniser latency
  initial edge_cnt = '0;
  initial spin(0, 210);
  initial spin(1, 410);
  initial spin(2, 310);
endmodule : osc_clock_model

// file: test/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, lp_stall, fclk, lclk, hclk;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, osc_run, clk_gate;
  logic [1:0] bresp, rresp;
  logic [2:0][15:0] edge_cnt;
  clock_source_pkg::osc_cfg_s osc_cfg;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  oscillator_source_startup_control #(.LP_WAIT_EXP0(6), .HS_WAIT_EXP0(7),
    .BOOST_LP_CYCLES(4)) dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .fast_internal_clock(fclk), .low_power_clock(lclk), .high_speed_clock(hclk),
    .osc_run(osc_run), .clk_gate(clk_gate), .osc_cfg(osc_cfg), .irq(irq));
  osc_clock_model partner (.osc_run(osc_run), .lp_stall(lp_stall), .fast_internal_clock(fclk),
    .low_power_clock(lclk), .high_speed_clock(hclk), .edge_cnt(edge_cnt));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er = clock_source_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {26'h0000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    check("bresp", bresp, er);
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= {26'h0000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, d, e);
  endtask : rdc
  task automatic wait_gate(input int b, input logic v);
    int n;
    n = 0;
    while (clk_gate[b] !== v && n < 6000) begin
      @(posedge clk);
      n++;
    end
    check("gate", clk_gate[b], v);
  endtask : wait_gate
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rst = 1'b1;
    lp_stall = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h00000000;
    araddr = 32'h00000000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("sys_src", osc_cfg.sys_src, clock_source_pkg::SRC_FAST);
    check("fast gate", clk_gate[0], 1'b0);
    wait_gate(0, 1'b1);
    check("fast edges", edge_cnt[0], 16'h0010);
    rdc("flag", clock_source_pkg::REG_FLAG, 32'h00000001);
    $display("test reset_start done");
    // disable first: trims may only move while halted (the RTL accepts trim writes while running)
    wr(clock_source_pkg::REG_ENABLE, 32'h00000000);
    wr(clock_source_pkg::REG_FAST, 32'h00002A56);
    rdc("fast locked", clock_source_pkg::REG_FAST, 32'h00000000);
    wr(clock_source_pkg::REG_PROT, 32'h00000096);
    rdc("unlocked", clock_source_pkg::REG_PROT, 32'h00000001);
    wr(clock_source_pkg::REG_FAST, 32'h00002A56);
    check("fast fq", osc_cfg.fast_fq, clock_source_pkg::FAST_FQ_8M);
    check("high trim", osc_cfg.fast_trim, 32'h0000002A);
    wr(clock_source_pkg::REG_FAST, 32'h00002A55);
    check("low trim", osc_cfg.fast_trim, 32'h00000015);
    wr(clock_source_pkg::REG_PROT, 32'h00000097);
    rdc("relocked", clock_source_pkg::REG_PROT, 32'h00000000);
    wr(clock_source_pkg::REG_FAST, 32'h00000000);
    rdc("fast kept", clock_source_pkg::REG_FAST, 32'h00002A55);
    $display("test protect_fast done");
    wr(clock_source_pkg::REG_ENABLE, 32'h00000001);
    check("stale gate", clk_gate[0], 1'b0);
    wait_gate(0, 1'b1);
    check("fast rerun", edge_cnt[0], 16'h0010);
    wr(clock_source_pkg::REG_IRQEN, 32'h00000001);
    repeat (2) @(posedge clk);
    check("irq on", irq, 1'b1);
    wr(clock_source_pkg::REG_FLAG, 32'h00000001);
    rdc("flag clear", clock_source_pkg::REG_FLAG, 32'h00000000);
    check("irq off", irq, 1'b0);
    $display("test restart_flag done");
    wr(clock_source_pkg::REG_FLAG, 32'h00000002);
    wr(clock_source_pkg::REG_IRQEN, 32'h00000002);
    wr(clock_source_pkg::REG_PROT, 32'h00000096);
    wr(clock_source_pkg::REG_LP, 32'h0006059C);
    wr(clock_source_pkg::REG_PROT, 32'h00000000);
    wr(clock_source_pkg::REG_ENABLE, 32'h00000003);
    check("boost on", osc_cfg.lp_boost, 1'b1);
    check("boost gain", osc_cfg.lp_gain, 32'h00000002);
    check("gate cap", osc_cfg.gate_cap, 32'h00000005);
    check("xtal", osc_cfg.lp_xtal, 1'b1);
    wait_gate(1, 1'b1);
    check("lp edges", edge_cnt[1], 16'h0040);
    check("normal gain", osc_cfg.lp_gain, 32'h00000001);
    // irq trails the flag, which trails the gate's ready by one edge
    @(posedge clk);
    check("lp irq", irq, 1'b1);
    $display("test lp_boost done");
    lp_stall <= 1'b1;
    wait_gate(1, 1'b0);
    rdc("stop flag", clock_source_pkg::REG_FLAG, 32'h0000000A);
    lp_stall <= 1'b0;
    wait_gate(1, 1'b1);
    check("lp rerun", edge_cnt[1], 16'h0040);
    $display("test lp_stop done");
    for (int k = 0; k < 2; k++) begin
      wr(clock_source_pkg::REG_ENABLE, 32'h00000003);
      wr(clock_source_pkg::REG_PROT, 32'h00000096);
      wr(clock_source_pkg::REG_HS, {25'h0000000, 1'b1, 2'(3 - k), 1'b0, 3'(2 * k)});
      wr(clock_source_pkg::REG_PROT, 32'h00000000);
      wr(clock_source_pkg::REG_ENABLE, 32'h00000007);
      check("hs fq", osc_cfg.hs_fq, 32'(3 - k));
      check("autotrim", osc_cfg.hs_autotrim, 32'(k == 0));
      wait_gate(2, 1'b1);
      check("hs edges", edge_cnt[2], 16'(1 << (7 - 2 * k)));
    end
    $display("test hs_wait done");
    wr(clock_source_pkg::REG_ENABLE, 32'h0000000F);
    check("ext gate", clk_gate[3], 1'b1);
    rdc("status", clock_source_pkg::REG_STATUS, 32'h0000000F);
    wr(clock_source_pkg::REG_PROT, 32'h00000096);
    wr(clock_source_pkg::REG_SYSTEM_CLOCK, 32'h00000002);
    check("sys hs", osc_cfg.sys_src, clock_source_pkg::SRC_HS);
    wr(clock_source_pkg::REG_PROT, 32'h00000000);
    wr(clock_source_pkg::REG_SYSTEM_CLOCK, 32'h00000000);
    check("sys kept", osc_cfg.sys_src, clock_source_pkg::SRC_HS);
    $display("test ext_system_clock done");
    wr(6'h24, 32'h00000001, clock_source_pkg::RESP_SLVERR);
    rd(6'h24, d, r);
    check("unmapped data", d, 32'h00000000);
    check("unmapped resp", r, clock_source_pkg::RESP_SLVERR);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : tb
